// ==== src/direct_command_decoder.sv ====
// Direct command decoder: turns command bytes into action strobes.
// Assumes command byte strobes from same-clock host port logic.
//
// Functional notes
// - C1 restores power-up state; always accepted, not chainable.
// - C2/C3 stop activity and clear FIFO; needs en; chainable.
// - C4 transmits with auto CRC; needs en and tx_en; chainable.
// - C5 transmits without CRC; needs en and tx_en; chainable.
// - C6 sends REQA; ISO14443A only; needs en, tx_en; chainable.
// - C7 sends WUPA; ISO14443A only; needs en, tx_en; chainable.
// - C8 initial collision avoidance, field on, interrupt at end; o_done_irq pulses in the same cycle as o_accepted.
// - C9/CA response collision avoidance (CA n=0), field on, irq.
// - CB goes to normal NFC only in bit-rate detection mode.
// - CC presets analog config from mode and bit rate; always ok.
// - D0 masks receive data; needs en and rx_en; chainable.
// - D1 unmasks receive, overriding mask timer; needs en, rx_en.
// - D3 measures amplitude into converter result; irq; no chain.
// - Command accepted only when all its listed enables are set.
`timescale 1ns/100ps

module direct_command_decoder
	import dcmd_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Command port
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	// Configuration and status inputs
	input  wire op_ctrl_t    i_op_ctrl,
	input  wire mode_stat_t  i_mode,
	// Amplitude converter
	input  wire logic        i_amp_done,
	input  wire logic [7:0]  i_amp_value,
	// Decode results
	output logic             o_accepted,
	output logic             o_rejected,
	output logic             o_chainable,
	output action_t          o_action,
	// Status
	output logic             o_rx_masked,
	output logic             o_meas_busy,
	output logic             o_done_irq,
	output logic [7:0]       o_adc_result
);

	// =====================================================================
	// Decode
	cmd_info_t info;
	action_t   act;

	always_comb begin
		info = '0;
		act  = ACTION_NONE;
		unique case (i_cmd_code)
			CMD_SET_DEFAULT: begin
				info = '{1'b1, 1'b1, 1'b0, 1'b0};
				act.set_default = 1'b1;
			end
			CMD_CLEAR_A, CMD_CLEAR_B: begin
				info = '{1'b1, i_op_ctrl.en, 1'b1, 1'b0};
				act.clear = 1'b1;
			end
			CMD_TX_CRC: begin
				info = '{1'b1, i_op_ctrl.en & i_op_ctrl.tx_en,
					1'b1, 1'b0};
				act.tx_crc = 1'b1;
			end
			CMD_TX_NOCRC: begin
				info = '{1'b1, i_op_ctrl.en & i_op_ctrl.tx_en,
					1'b1, 1'b0};
				act.tx_nocrc = 1'b1;
			end
			CMD_TX_REQA: begin
				info = '{1'b1, i_op_ctrl.en & i_op_ctrl.tx_en
					& i_mode.iso14443a, 1'b1, 1'b0};
				act.tx_reqa = 1'b1;
			end
			CMD_TX_WUPA: begin
				info = '{1'b1, i_op_ctrl.en & i_op_ctrl.tx_en
					& i_mode.iso14443a, 1'b1, 1'b0};
				act.tx_wupa = 1'b1;
			end
			CMD_FIELD_INIT: begin
				info = '{1'b1, i_op_ctrl.en, 1'b1, 1'b1};
				act.field_init = 1'b1;
			end
			CMD_FIELD_RESP: begin
				info = '{1'b1, i_op_ctrl.en, 1'b1, 1'b1};
				act.field_resp = 1'b1;
			end
			CMD_FIELD_RESP_N0: begin
				info = '{1'b1, i_op_ctrl.en, 1'b1, 1'b1};
				act.field_resp_n0 = 1'b1;
			end
			CMD_NORMAL_NFC: begin
				info = '{1'b1, i_mode.bitrate_detect,
					1'b1, 1'b0};
				act.normal_nfc = 1'b1;
			end
			CMD_ANALOG_PRESET: begin
				info = '{1'b1, 1'b1, 1'b1, 1'b0};
				act.analog_preset = 1'b1;
			end
			CMD_MASK_RX, CMD_UNMASK_RX: begin
				info = '{1'b1, i_op_ctrl.en & i_op_ctrl.rx_en,
					1'b1, 1'b0};
			end
			CMD_MEAS_AMP: begin
				info = '{1'b1, i_op_ctrl.en, 1'b0, 1'b1};
				act.meas_amp = 1'b1;
			end
			default: begin
				info = '0;
			end
		endcase
	end

	logic take;
	assign take = i_cmd_valid & info.known & info.allowed;

	// =====================================================================
	// State
	logic        rx_masked;
	logic        meas_busy;
	logic        irq_pend;
	logic [7:0]  adc_result;
	logic        accepted;
	logic        rejected;
	logic        chainable;
	action_t     action;
	logic        next_rx_masked;
	logic        next_meas_busy;
	logic        next_irq_pend;
	logic [7:0]  next_adc_result;
	logic        next_accepted;
	logic        next_rejected;
	logic        next_chainable;
	action_t     next_action;

	// Field commands end via the field logic; only the amplitude
	// measurement completion is tracked here, others pulse at once.
	always_comb begin
		next_accepted   = take;
		next_rejected   = i_cmd_valid & info.known & ~info.allowed;
		next_chainable  = take & info.chainable;
		next_action     = take ? act : ACTION_NONE;
		next_rx_masked  = rx_masked;
		next_meas_busy  = meas_busy;
		next_adc_result = adc_result;
		next_irq_pend   = 1'b0;
		if (take && i_cmd_code == CMD_MASK_RX)
			next_rx_masked = 1'b1;
		if (take && i_cmd_code == CMD_UNMASK_RX)
			next_rx_masked = 1'b0;
		if (meas_busy && i_amp_done) begin
			next_meas_busy  = 1'b0;
			next_adc_result = i_amp_value;
			next_irq_pend   = 1'b1;
		end
		// New measurement beats the old one finishing
		if (take && act.meas_amp)
			next_meas_busy = 1'b1;
		if (take && (act.field_init | act.field_resp | act.field_resp_n0))
			next_irq_pend = 1'b1;
		if (take && act.set_default) begin
			next_rx_masked  = RX_MASK_RESET;
			next_meas_busy  = 1'b0;
			next_adc_result = ADC_RESULT_RESET;
			next_irq_pend   = 1'b0;
		end
		if (take && act.clear)
			next_meas_busy = 1'b0;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rx_masked  <= RX_MASK_RESET;
			meas_busy  <= 1'b0;
			irq_pend   <= 1'b0;
			adc_result <= ADC_RESULT_RESET;
			accepted   <= 1'b0;
			rejected   <= 1'b0;
			chainable  <= 1'b0;
			action     <= ACTION_NONE;
		end else begin
			rx_masked  <= next_rx_masked;
			meas_busy  <= next_meas_busy;
			irq_pend   <= next_irq_pend;
			adc_result <= next_adc_result;
			accepted   <= next_accepted;
			rejected   <= next_rejected;
			chainable  <= next_chainable;
			action     <= next_action;
		end
	end

	assign o_accepted   = accepted;
	assign o_rejected   = rejected;
	assign o_chainable  = chainable;
	assign o_action     = action;
	assign o_rx_masked  = rx_masked;
	assign o_meas_busy  = meas_busy;
	assign o_done_irq   = irq_pend;
	assign o_adc_result = adc_result;

	// =====================================================================
	// Assertions
	a_reject_no_en: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_TX_CRC && !i_op_ctrl.tx_en
		|=> !o_accepted && o_rejected)
		else $error("tx with crc taken without tx enable");
	a_setdef_any: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_SET_DEFAULT
		|=> o_action.set_default && !o_chainable && !o_rx_masked)
		else $error("set default not taken");
	a_clear_en: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_CLEAR_B && i_op_ctrl.en
		|=> o_action.clear && o_chainable)
		else $error("clear not taken");
	a_txcrc_go: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_TX_CRC && i_op_ctrl.en
		&& i_op_ctrl.tx_en |=> o_action.tx_crc && o_chainable)
		else $error("tx with crc missing");
	a_txnocrc_go: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_TX_NOCRC && i_op_ctrl.en
		&& i_op_ctrl.tx_en |=> o_action.tx_nocrc)
		else $error("tx without crc missing");
	a_reqa_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_action.tx_reqa |-> $past(i_mode.iso14443a))
		else $error("reqa outside iso14443a");
	a_wupa_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_action.tx_wupa |-> $past(i_mode.iso14443a)
		&& $past(i_op_ctrl.tx_en))
		else $error("wupa outside allowed mode");
	a_field_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_action.field_init || o_action.field_resp
		|| o_action.field_resp_n0) |-> o_done_irq)
		else $error("field command without interrupt");
	a_nfc_detect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_action.normal_nfc |-> $past(i_mode.bitrate_detect))
		else $error("normal nfc outside detect mode");
	a_preset_any: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_ANALOG_PRESET
		|=> o_action.analog_preset)
		else $error("analog preset not taken");
	a_mask_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_MASK_RX && i_op_ctrl.en
		&& i_op_ctrl.rx_en |=> o_rx_masked)
		else $error("receive not masked");
	a_unmask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_UNMASK_RX && i_op_ctrl.en
		&& i_op_ctrl.rx_en |=> !o_rx_masked)
		else $error("receive not unmasked");
	a_amp_store: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_meas_busy && i_amp_done && !(i_cmd_valid && i_cmd_code
		== CMD_SET_DEFAULT) |=> o_adc_result == $past(i_amp_value)
		&& o_done_irq
		&& o_meas_busy == o_action.meas_amp)
		else $error("amplitude result not stored");
	a_meas_again: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_meas_busy && i_amp_done && i_cmd_valid && i_op_ctrl.en
		&& i_cmd_code == CMD_MEAS_AMP |=> o_meas_busy)
		else $error("restarted measurement not busy");
	a_rej_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_MASK_RX && !i_op_ctrl.rx_en
		|=> o_rejected
		&& o_rx_masked == $past(o_rx_masked))
		else $error("refused mask changed state");
	a_meas_rej: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_MEAS_AMP && !i_op_ctrl.en
		|=> o_rejected && !o_action.meas_amp)
		else $error("measurement taken without enable");
	a_meas_chain: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_action.meas_amp |-> o_accepted && !o_chainable)
		else $error("measurement flagged chainable");
	a_clear_stop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_CLEAR_A && i_op_ctrl.en
		|=> !o_meas_busy && o_action.clear)
		else $error("clear did not stop measurement");
	a_reqa_rej: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == CMD_TX_REQA && !i_mode.iso14443a
		|=> o_rejected && !o_action.tx_reqa)
		else $error("reqa taken outside iso14443a");
	a_init_chain: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_action.field_init |-> o_chainable && o_done_irq)
		else $error("initial field command not chainable");
	a_unused_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cmd_valid && i_cmd_code == 8'hD2
		|=> !o_accepted && !o_rejected && o_action == ACTION_NONE)
		else $error("unused code had effect");

	c_tx_crc:  cover property (@(posedge i_clk_sys) o_action.tx_crc);
	c_reject:  cover property (@(posedge i_clk_sys) o_rejected);
	c_amp:     cover property (@(posedge i_clk_sys)
		o_meas_busy && i_amp_done);
	c_field:   cover property (@(posedge i_clk_sys) o_action.field_resp_n0);
	c_set_def: cover property (@(posedge i_clk_sys) o_action.set_default);

endmodule

// ==== common/dcmd_pkg.sv ====
// Package for the direct command decoder: codes, enables, actions.
// Assumes one system clock; commands arrive as one-cycle byte strobes.
package dcmd_pkg;

	// =====================================================================
	// Command codes
	localparam logic [7:0] CMD_SET_DEFAULT   = 8'hC1;
	localparam logic [7:0] CMD_CLEAR_A       = 8'hC2;
	localparam logic [7:0] CMD_CLEAR_B       = 8'hC3;
	localparam logic [7:0] CMD_TX_CRC        = 8'hC4;
	localparam logic [7:0] CMD_TX_NOCRC      = 8'hC5;
	localparam logic [7:0] CMD_TX_REQA       = 8'hC6;
	localparam logic [7:0] CMD_TX_WUPA       = 8'hC7;
	localparam logic [7:0] CMD_FIELD_INIT    = 8'hC8;
	localparam logic [7:0] CMD_FIELD_RESP    = 8'hC9;
	localparam logic [7:0] CMD_FIELD_RESP_N0 = 8'hCA;
	localparam logic [7:0] CMD_NORMAL_NFC    = 8'hCB;
	localparam logic [7:0] CMD_ANALOG_PRESET = 8'hCC;
	localparam logic [7:0] CMD_MASK_RX       = 8'hD0;
	localparam logic [7:0] CMD_UNMASK_RX     = 8'hD1;
	localparam logic [7:0] CMD_MEAS_AMP      = 8'hD3;

	// =====================================================================
	// Reset values
	localparam logic       RX_MASK_RESET     = 1'b0;
	localparam logic [7:0] ADC_RESULT_RESET  = 8'h00;

	// =====================================================================
	// Operation control enables and mode status
	typedef struct packed {
		logic en;
		logic tx_en;
		logic rx_en;
	} op_ctrl_t;

	typedef struct packed {
		logic iso14443a;
		logic bitrate_detect;
	} mode_stat_t;

	// One-cycle action strobes toward the rest of the device
	typedef struct packed {
		logic set_default;
		logic clear;
		logic tx_crc;
		logic tx_nocrc;
		logic tx_reqa;
		logic tx_wupa;
		logic field_init;
		logic field_resp;
		logic field_resp_n0;
		logic normal_nfc;
		logic analog_preset;
		logic meas_amp;
	} action_t;

	localparam action_t ACTION_NONE = '0;

	// Command decode result
	typedef struct packed {
		logic known;
		logic allowed;
		logic chainable;
		logic irq_on_done;
	} cmd_info_t;

endpackage

// ==== verif/amp_converter_model.sv ====
// Behavioural amplitude converter standing beside the command decoder.
// Assumes the meas_amp action strobe starts it; one system clock.
`timescale 1ns/100ps

module amp_converter_model (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	// Control
	input  wire logic       i_start,
	input  wire logic [7:0] i_delay,
	// Result
	output logic            o_done,
	output logic [7:0]      o_value
);
	// =====================================================================
	// Conversion timing
	logic [7:0] cnt;
	logic [7:0] churn;

	// Value churns every cycle; only meaningful with o_done
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt    <= 8'h00;
			o_done <= 1'b0;
			churn  <= 8'h00;
		end else begin
			o_done <= (cnt == 8'h01);
			if (i_start)
				cnt <= i_delay;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			churn <= churn + 8'h3B;
		end
	end
	assign o_value = churn;
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the direct command decoder.
// Assumes the decoder and the converter model share one clock.
`timescale 1ns/100ps

module testbench;
	import dcmd_pkg::*;
	// =====================================================================
	// Signals
	logic        clk = 0, rst_n = 0, valid = 0, adone, acc, rej, chain;
	logic        mask, busy, irq;
	logic [7:0]  code = 8'h00, aval, res, dly = 8'h01;
	op_ctrl_t    op = '0;
	mode_stat_t  md = '0;
	action_t     act;
	int          n_errors = 0, compares = 0, k, ok, ch, idx;
	logic [31:0] lf = 32'h7D02E39E;
	logic        e_acc = 0, e_rej = 0, e_ch = 0, e_irq = 0;
	logic        m_mask = 0, m_busy = 0, c1;
	logic [11:0] e_act = 12'h000;
	logic [7:0]  m_res = 8'h00;

	always #5 clk = ~clk;

	direct_command_decoder DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_cmd_valid(valid), .i_cmd_code(code), .i_op_ctrl(op),
		.i_mode(md), .i_amp_done(adone), .i_amp_value(aval),
		.o_accepted(acc), .o_rejected(rej), .o_chainable(chain),
		.o_action(act), .o_rx_masked(mask), .o_meas_busy(busy),
		.o_done_irq(irq), .o_adc_result(res));
	amp_converter_model conv (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_start(act.meas_amp), .i_delay(dly), .o_done(adone),
		.o_value(aval));

	// =====================================================================
	// Reference model
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Known flag, enable check, chaining, action bit (-1 for none)
	task automatic dec(input logic [7:0] c);
		k = 1; ch = 1; idx = -1;
		case (c)
			8'hC1: begin ok = 1; ch = 0; idx = 11; end
			8'hC2, 8'hC3: begin ok = op.en; idx = 10; end
			8'hC4: begin ok = op.en & op.tx_en; idx = 9; end
			8'hC5: begin ok = op.en & op.tx_en; idx = 8; end
			8'hC6: begin ok = op.en & op.tx_en & md.iso14443a; idx = 7; end
			8'hC7: begin ok = op.en & op.tx_en & md.iso14443a; idx = 6; end
			8'hC8: begin ok = op.en; idx = 5; end
			8'hC9: begin ok = op.en; idx = 4; end
			8'hCA: begin ok = op.en; idx = 3; end
			8'hCB: begin ok = md.bitrate_detect; idx = 2; end
			8'hCC: begin ok = 1; idx = 1; end
			8'hD0, 8'hD1: ok = op.en & op.rx_en;
			8'hD3: begin ok = op.en; ch = 0; idx = 0; end
			default: begin k = 0; ok = 0; end
		endcase
	endtask

	always @(posedge clk) begin
		if (!rst_n) begin
			{e_acc, e_rej, e_ch, e_irq, m_mask, m_busy} = 6'h00;
			e_act = 12'h000;
			m_res = 8'h00;
		end else begin
			dec(code);
			e_acc = valid & k & ok;
			e_rej = valid & k & !ok;
			e_ch = e_acc & ch;
			e_act = (e_acc && idx >= 0) ? 12'h001 << idx : 12'h000;
			c1 = e_acc && code == 8'hC1;
			e_irq = 0;
			if (adone && m_busy && !c1) begin
				m_res = aval;
				m_busy = 0;
				e_irq = 1;
			end
			if (e_acc && code >= 8'hC8 && code <= 8'hCA) e_irq = 1;
			if (e_acc && code == 8'hD0) m_mask = 1;
			if (e_acc && code == 8'hD1) m_mask = 0;
			if (e_acc && (code == 8'hC2 || code == 8'hC3)) m_busy = 0;
			if (e_acc && code == 8'hD3) m_busy = 1;
			if (c1) begin
				{m_mask, m_busy, e_irq} = 3'h0;
				m_res = 8'h00;
			end
		end
	end

	// =====================================================================
	// Comparison
	task automatic chk(input string n, input logic [11:0] e, g);
		compares++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask

	always @(negedge clk) begin
		chk("accepted", {11'h000, e_acc}, {11'h000, acc});
		chk("rejected", {11'h000, e_rej}, {11'h000, rej});
		chk("chainable", {11'h000, e_ch}, {11'h000, chain});
		chk("action", e_act, act);
		chk("rx_masked", {11'h000, m_mask}, {11'h000, mask});
		chk("meas_busy", {11'h000, m_busy}, {11'h000, busy});
		chk("done_irq", {11'h000, e_irq}, {11'h000, irq});
		chk("adc_result", {4'h0, m_res}, {4'h0, res});
	end

	task automatic tally_and_finish;
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// =====================================================================
	// Stimulus: full sweep of codes and enables, then random traffic
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		valid = 1;
		for (int i = 0; i < 20; i++) begin
			for (int p = 0; p < 32; p++) begin
				code = 8'hC0 + i[7:0];
				op = p[2:0];
				md = p[4:3];
				@(negedge clk);
			end
		end
		repeat (4000) begin
			lf = nxt(lf);
			valid = lf[0];
			code = (lf[3:1] == 3'h0) ? lf[15:8] : 8'hC0 + 8'(lf[12:8] % 20);
			op = lf[18:16] | {lf[26], 2'b00};
			md = lf[20:19];
			dly = 8'h01 + {3'h0, lf[25:21]};
			rst_n = (lf[31:24] != 8'h00);
			@(negedge clk);
		end
		tally_and_finish();
	end

	// Run needs about 4650 cycles; generous margin
	initial begin
		#1000000;
		n_errors++;
		tally_and_finish();
	end
endmodule
